// *** rtl/osc_select_warmup_ctrl.sv ***
// Clock source select, oscillator enables and warm-up ready tracking
//
// Operation
// - Select bit picks crystal, else RC clock
// - Select set needs main ready, main enabled
// - RC flag shows clock actually in use
// - Resume: RC at once, or hold for crystal
// - Sub disable bit stops 32 kHz oscillator
// - Main disable accepted only on RC clock
// - Main re-enable restarts warm-up, then ready
// - Main ready cleared on resume or disable
// - Main ready is set after power-on reset
// - Main warm-up 4096 or 65536, by option
// - Sub ready after warm-up, cleared on disable
// - Sub warm-up 1024 or 65536, by option
// - High in-service set on entry, RETI clears
// - Low in-service set on entry, RETI clears when high is not in service
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module osc_select_warmup_ctrl
    import osc_ctrl_pkg::*;
#(
    parameter int MAIN_SHORT = MAIN_WARM_SHORT,
    parameter int MAIN_LONG = MAIN_WARM_LONG,
    parameter int SUB_SHORT = SUB_WARM_SHORT,
    parameter int SUB_LONG = SUB_WARM_LONG
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [osc_ctrl_pkg::APB_AW-1:0] paddr,
    input wire logic [osc_ctrl_pkg::DW-1:0] pwdata,
    output logic [osc_ctrl_pkg::DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator pins and factory option straps
    input wire logic main_osc_clk,
    input wire logic sub_osc_clk,
    input wire logic main_warm_long_opt,
    input wire logic sub_warm_long_opt,
    // CPU events, same clock
    input wire logic pd_exit,
    input wire logic irq_enter_high,
    input wire logic irq_enter_low,
    input wire logic reti,
    // Clock controls
    output logic main_osc_en,
    output logic sub_osc_en,
    output logic sys_clk_crystal,
    output logic cpu_hold,
    output logic irq
);
    import osc_ctrl_pkg::*;

    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction

    // Pin synchronisers
    logic [2:0] main_clk_s_r;
    logic [2:0] sub_clk_s_r;
    logic [1:0] main_opt_s_r;
    logic [1:0] sub_opt_s_r;
    logic opt_taken_r;
    logic main_long_r;
    logic sub_long_r;

    // Control and status
    logic src_sel_r;
    logic rc_active_r;
    logic res_sel_r;
    logic sub_dis_r;
    logic main_dis_r;
    logic main_rdy_r;
    logic sub_rdy_r;
    logic high_svc_r;
    logic low_svc_r;
    logic hold_r;
    logic [CNT_W-1:0] main_cnt_r;
    logic [CNT_W-1:0] sub_cnt_r;
    logic main_run_r;
    logic sub_run_r;
    logic [EVT_W-1:0] evt_sts_r;
    logic [EVT_W-1:0] evt_en_r;
    logic irq_r;
    logic main_run_q_r;
    logic sub_run_q_r;
    logic [1:0] opt_cnt_r;

    // Strap read once the synchroniser holds the pin value
    localparam logic [1:0] OPT_SETTLE = 2'h2;

    // APB
    logic [DW-1:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    logic setup_acc;
    logic wr_done;
    logic hit_pmr;
    logic hit_clr;
    logic hit_en;
    logic mapped;
    logic main_edge;
    logic sub_edge;
    logic [CNT_W-1:0] main_term;
    logic [CNT_W-1:0] sub_term;
    logic main_rdy_nxt;
    logic sub_rdy_nxt;
    logic [EVT_W-1:0] evt_set;
    logic [RW-1:0] pmr_val;
    logic [RW-1:0] status_val;

    assign setup_acc = psel & penable & ~pready_r;
    assign wr_done = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign hit_pmr = paddr == reg_addr(IDX_PMR);
    assign hit_clr = paddr == reg_addr(IDX_IRQ_CLR);
    assign hit_en = paddr == reg_addr(IDX_IRQ_EN);
    assign mapped = hit_pmr | hit_clr | hit_en
                  | (paddr == reg_addr(IDX_STATUS))
                  | (paddr == reg_addr(IDX_IRQ_STS));
    assign main_edge = rise(main_clk_s_r[1], main_clk_s_r[2]);
    assign sub_edge = rise(sub_clk_s_r[1], sub_clk_s_r[2]);

    always_comb begin
        pmr_val = '0;
        pmr_val[PMR_SRC_SEL] = src_sel_r;
        pmr_val[PMR_RC_ACT] = rc_active_r;
        pmr_val[PMR_RES_SEL] = res_sel_r;
        pmr_val[PMR_SUB_DIS] = sub_dis_r;
        pmr_val[PMR_MAIN_DIS] = main_dis_r;
        pmr_val[PMR_ONE] = PMR_RESET[PMR_ONE];
        status_val = STATUS_RESET;
        status_val[ST_SUB_RDY] = sub_rdy_r;
        status_val[ST_HIGH_SVC] = high_svc_r;
        status_val[ST_LOW_SVC] = low_svc_r;
        status_val[ST_MAIN_RDY] = main_rdy_r;
    end

    // Two stages on every pin before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_clk_s_r <= '0;
            sub_clk_s_r <= '0;
            main_opt_s_r <= '0;
            sub_opt_s_r <= '0;
        end else begin
            main_clk_s_r <= {main_clk_s_r[1:0], main_osc_clk};
            sub_clk_s_r <= {sub_clk_s_r[1:0], sub_osc_clk};
            main_opt_s_r <= {main_opt_s_r[0], main_warm_long_opt};
            sub_opt_s_r <= {sub_opt_s_r[0], sub_warm_long_opt};
        end
    end

    // Options are straps: caught once after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_taken_r <= 1'b0;
            opt_cnt_r <= '0;
            main_long_r <= 1'b1;
            sub_long_r <= 1'b1;
        end else if (!opt_taken_r && opt_cnt_r != OPT_SETTLE) begin
            opt_cnt_r <= opt_cnt_r + 2'h1;
        end else if (!opt_taken_r) begin
            opt_taken_r <= 1'b1;
            main_long_r <= main_opt_s_r[1];
            sub_long_r <= sub_opt_s_r[1];
        end
    end

    assign main_term = main_long_r ? CNT_W'(MAIN_LONG) : CNT_W'(MAIN_SHORT);
    assign sub_term = sub_long_r ? CNT_W'(SUB_LONG) : CNT_W'(SUB_SHORT);

    // POWER_CLOCK_MANAGE writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel_r <= PMR_RESET[PMR_SRC_SEL];
            res_sel_r <= PMR_RESET[PMR_RES_SEL];
            sub_dis_r <= PMR_RESET[PMR_SUB_DIS];
            main_dis_r <= PMR_RESET[PMR_MAIN_DIS];
        end else begin
            if (wr_done && hit_pmr) begin
                res_sel_r <= pwdata[PMR_RES_SEL];
                sub_dis_r <= pwdata[PMR_SUB_DIS];
                if (!pwdata[PMR_SRC_SEL])
                    src_sel_r <= 1'b0;
                else if (main_rdy_r && !main_dis_r)
                    src_sel_r <= 1'b1;
                if (!pwdata[PMR_MAIN_DIS])
                    main_dis_r <= 1'b0;
                else if (!src_sel_r && !rc_active_r)
                    main_dis_r <= 1'b0;
                else if (!src_sel_r)
                    main_dis_r <= 1'b1;
            end
            if (pd_exit && res_sel_r)
                src_sel_r <= 1'b0;
        end
    end

    // Clock in use follows the select one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_active_r <= PMR_RESET[PMR_RC_ACT];
            sys_clk_crystal <= PMR_RESET[PMR_SRC_SEL];
        end else begin
            rc_active_r <= ~src_sel_r;
            sys_clk_crystal <= src_sel_r;
        end
    end

    // Crystal warm-up; restart on resume or re-enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_cnt_r <= '0;
            main_run_r <= 1'b0;
            main_rdy_r <= 1'b1;
        end else if (main_dis_r || pd_exit) begin
            main_cnt_r <= '0;
            main_run_r <= ~main_dis_r;
            main_rdy_r <= 1'b0;
        end else if (!main_rdy_r && !main_run_r) begin
            main_cnt_r <= '0;
            main_run_r <= 1'b1;
        end else if (main_run_r && main_edge) begin
            main_cnt_r <= main_cnt_r + CNT_W'(1);
            if (main_cnt_r + CNT_W'(1) == main_term) begin
                main_run_r <= 1'b0;
                main_rdy_r <= 1'b1;
            end
        end
    end

    // Sub-oscillator warm-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_cnt_r <= '0;
            sub_run_r <= 1'b1;
            sub_rdy_r <= STATUS_RESET[ST_SUB_RDY];
        end else if (sub_dis_r) begin
            sub_cnt_r <= '0;
            sub_run_r <= 1'b1;
            sub_rdy_r <= 1'b0;
        end else if (sub_run_r && !sub_rdy_r && sub_edge) begin
            sub_cnt_r <= sub_cnt_r + CNT_W'(1);
            if (sub_cnt_r + CNT_W'(1) == sub_term) begin
                sub_run_r <= 1'b0;
                sub_rdy_r <= 1'b1;
            end
        end
    end

    // Resume hold until crystal is warm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            hold_r <= 1'b0;
        else if (pd_exit && !res_sel_r)
            hold_r <= 1'b1;
        else if (main_rdy_r)
            hold_r <= 1'b0;
    end

    // Interrupt level in service; entry beats RETI
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_svc_r <= STATUS_RESET[ST_HIGH_SVC];
            low_svc_r <= STATUS_RESET[ST_LOW_SVC];
        end else begin
            if (irq_enter_high)
                high_svc_r <= 1'b1;
            else if (reti && high_svc_r)
                high_svc_r <= 1'b0;
            if (irq_enter_low)
                low_svc_r <= 1'b1;
            else if (reti && !high_svc_r)
                low_svc_r <= 1'b0;
        end
    end

    // Sticky events; set wins over clear
    assign main_rdy_nxt = main_rdy_r;
    assign sub_rdy_nxt = sub_rdy_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Match the flags' reset, else a false event follows reset
            main_run_q_r <= 1'b1;
            sub_run_q_r <= STATUS_RESET[ST_SUB_RDY];
        end else begin
            main_run_q_r <= main_rdy_nxt;
            sub_run_q_r <= sub_rdy_nxt;
        end
    end

    always_comb begin
        evt_set = '0;
        evt_set[EV_MAIN_RDY] = rise(main_rdy_r, main_run_q_r);
        evt_set[EV_SUB_RDY] = rise(sub_rdy_r, sub_run_q_r);
        evt_set[EV_RESUME] = pd_exit;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_sts_r <= '0;
            evt_en_r <= '0;
            irq_r <= 1'b0;
        end else begin
            if (wr_done && hit_clr)
                evt_sts_r <= (evt_sts_r & ~pwdata[EVT_W-1:0]) | evt_set;
            else
                evt_sts_r <= evt_sts_r | evt_set;
            if (wr_done && hit_en)
                evt_en_r <= pwdata[EVT_W-1:0];
            irq_r <= |(evt_sts_r & evt_en_r);
        end
    end

    // APB: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= setup_acc;
            pslverr_r <= setup_acc & ~mapped;
            if (setup_acc && !pwrite) begin
                unique case (1'b1)
                    hit_pmr: prdata_r <= DW'(pmr_val);
                    paddr == reg_addr(IDX_STATUS):
                        prdata_r <= DW'(status_val);
                    paddr == reg_addr(IDX_IRQ_STS):
                        prdata_r <= DW'(evt_sts_r);
                    hit_en: prdata_r <= DW'(evt_en_r);
                    default: prdata_r <= '0;
                endcase
            end else if (setup_acc) begin
                prdata_r <= '0;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;
    assign cpu_hold = hold_r;
    assign main_osc_en = ~main_dis_r;
    assign sub_osc_en = ~sub_dis_r;

    a_src_set_gate: assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && hit_pmr && pwdata[PMR_SRC_SEL] && !src_sel_r
        && !(main_rdy_r && !main_dis_r) && !pd_exit |=> !src_sel_r)
        else $error("select set without warm crystal");
    a_rc_flag_match: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 rc_active_r == !$past(src_sel_r))
        else $error("rc flag does not follow source");
    a_clk_out_match: assert property (@(posedge pclk) disable iff (!presetn)
        sys_clk_crystal == !rc_active_r)
        else $error("clock output disagrees with flag");
    a_main_dis_gate: assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && hit_pmr && src_sel_r && !main_dis_r |=> !main_dis_r)
        else $error("crystal stopped while in use");
    a_main_rdy_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (main_dis_r || pd_exit) |=> !main_rdy_r [*2])
        else $error("main ready not cleared");
    a_sub_rdy_clear: assert property (@(posedge pclk) disable iff (!presetn)
        sub_dis_r |=> !sub_rdy_r)
        else $error("sub ready not cleared");
    a_resume_rc_now: assert property (@(posedge pclk) disable iff (!presetn)
        pd_exit && res_sel_r |=> !src_sel_r ##1 rc_active_r && !cpu_hold)
        else $error("resume did not go to rc");
    a_resume_hold: assert property (@(posedge pclk) disable iff (!presetn)
        pd_exit && !res_sel_r |=> cpu_hold throughout (!main_rdy_r [*2]))
        else $error("resume hold missing");
    a_high_svc_set: assert property (@(posedge pclk) disable iff (!presetn)
        irq_enter_high |=> high_svc_r)
        else $error("high in-service not set");
    a_low_svc_clear: assert property (@(posedge pclk) disable iff (!presetn)
        reti && !high_svc_r && !irq_enter_low |=> !low_svc_r)
        else $error("low in-service not cleared");
    a_main_warm_end: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(main_rdy_r) |-> $past(main_cnt_r) + CNT_W'(1) == main_term)
        else $error("main ready before warm-up count");
endmodule // osc_select_warmup_ctrl
`default_nettype wire

// *** rtl/osc_ctrl_pkg.sv ***
// Constants for oscillator select and warm-up control
package osc_ctrl_pkg;
    localparam int APB_AW = 12;
    localparam int DW = 32;
    localparam int RW = 8;
    localparam int CNT_W = 17;
    localparam int EVT_W = 3;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PMR = 8'hc4;
    localparam logic [7:0] IDX_STATUS = 8'hc5;
    localparam logic [7:0] IDX_IRQ_STS = 8'hd0;
    localparam logic [7:0] IDX_IRQ_EN = 8'hd1;
    localparam logic [7:0] IDX_IRQ_CLR = 8'hd2;

    // Power and clock manage fields
    localparam int PMR_SRC_SEL = 7;
    localparam int PMR_RC_ACT = 6;
    localparam int PMR_RES_SEL = 5;
    localparam int PMR_SUB_DIS = 4;
    localparam int PMR_MAIN_DIS = 3;
    localparam int PMR_ONE = 0;
    localparam logic [RW-1:0] PMR_RESET = 8'h81;

    // Status fields
    localparam int ST_SUB_RDY = 7;
    localparam int ST_HIGH_SVC = 6;
    localparam int ST_LOW_SVC = 5;
    localparam int ST_MAIN_RDY = 4;
    localparam logic [RW-1:0] STATUS_RESET = 8'h00;

    // Event bits of the interrupt status, enable and clear registers
    localparam int EV_MAIN_RDY = 0;
    localparam int EV_SUB_RDY = 1;
    localparam int EV_RESUME = 2;

    // Warm-up lengths in oscillator clocks
    localparam int MAIN_WARM_SHORT = 4096;
    localparam int MAIN_WARM_LONG = 65536;
    localparam int SUB_WARM_SHORT = 1024;
    localparam int SUB_WARM_LONG = 65536;

    function automatic logic [APB_AW-1:0] reg_addr(input logic [7:0] idx);
        reg_addr = {2'h0, idx, 2'h0};
    endfunction
endpackage

// *** verification/osc_partner.sv ***
// Behavioural crystal and sub-oscillator pins for the clock block
`timescale 1ns/1ps
`default_nettype none
module osc_partner (
    // Enables from the block
    input wire logic main_osc_en,
    input wire logic sub_osc_en,
    // Oscillator clocks
    output var logic main_osc_clk,
    output var logic sub_osc_clk
);
    logic main_run;
    logic sub_run;
    // Periods well above two pclk cycles, so the synchroniser sees each edge
    initial begin
        main_run = 1'b0;
        forever #20 main_run = ~main_run;
    end
    initial begin
        sub_run = 1'b0;
        forever #28 sub_run = ~sub_run;
    end
    // A stopped oscillator holds its pin low
    always_comb main_osc_clk = main_osc_en & main_run;
    always_comb sub_osc_clk = sub_osc_en & sub_run;
endmodule // osc_partner
`default_nettype wire

// *** verification/tb_osc_select_warmup_ctrl.sv ***
// Self-checking bench for the oscillator select and warm-up block
`timescale 1ns/1ps
`default_nettype none
module tb_osc_select_warmup_ctrl;
    import osc_ctrl_pkg::*;
    localparam logic [11:0] A_PMR = {2'h0, IDX_PMR, 2'h0};
    localparam logic [11:0] A_ST = {2'h0, IDX_STATUS, 2'h0};
    localparam logic [11:0] A_STS = {2'h0, IDX_IRQ_STS, 2'h0};
    localparam logic [11:0] A_EN = {2'h0, IDX_IRQ_EN, 2'h0};
    localparam logic [11:0] A_CLR = {2'h0, IDX_IRQ_CLR, 2'h0};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [DW-1:0] pwdata, prdata;
    logic main_osc_clk, sub_osc_clk, main_osc_en, sub_osc_en;
    logic sys_clk_crystal, cpu_hold, irq;
    logic [3:0] ev;
    logic main_long_opt, sub_long_opt;
    int num_errors = 0;
    int n_checks = 0;

    osc_select_warmup_ctrl #(.MAIN_SHORT(8), .MAIN_LONG(16), .SUB_SHORT(4),
        .SUB_LONG(16)) osc_select_warmup_ctrl_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .main_osc_clk(main_osc_clk),
        .sub_osc_clk(sub_osc_clk), .main_warm_long_opt(main_long_opt),
        .sub_warm_long_opt(sub_long_opt), .pd_exit(ev[0]),
        .irq_enter_high(ev[1]),
        .irq_enter_low(ev[2]), .reti(ev[3]), .main_osc_en(main_osc_en),
        .sub_osc_en(sub_osc_en), .sys_clk_crystal(sys_clk_crystal),
        .cpu_hold(cpu_hold), .irq(irq));
    osc_partner osc_partner_i (.main_osc_en(main_osc_en),
        .sub_osc_en(sub_osc_en), .main_osc_clk(main_osc_clk),
        .sub_osc_clk(sub_osc_clk));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            num_errors++;
            $display("mismatch pready expected 1 seen 0");
            print_verdict();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rchk(input string what, input logic [11:0] a,
                        input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(what, exp, rd & mask);
    endtask
    // Poll a register until a bit sets, with a bounded number of reads
    task automatic wait_bit(input string what, input logic [11:0] a,
                            input logic [31:0] mask);
        logic [31:0] rd;
        logic err;
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, a, 32'h0, rd, err);
            if ((rd & mask) === mask) begin
                return;
            end
        end
        chk(what, mask, rd & mask);
        print_verdict();
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge pclk);
        ev <= m;
        @(posedge pclk);
        ev <= 4'h0;
    endtask

    task automatic t_reset();
        logic [31:0] rd;
        logic err;
        rchk("pmr reset", A_PMR, 32'hff, 32'h81);
        rchk("status reset", A_ST, 32'hff, 32'h10);
        chk("crystal at reset", 32'h1, {31'h0, sys_clk_crystal});
        wr(A_ST, 32'h0);
        rchk("status read only", A_ST, 32'hff, 32'h10);
        apb(1'b0, 12'h004, 32'h0, rd, err);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        rchk("no event at reset", A_STS, 32'h1, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_main_off();
        wr(A_PMR, 32'h89);
        rchk("disable on crystal", A_PMR, 32'hff, 32'h81);
        wr(A_PMR, 32'h01);
        cyc(2);
        chk("rc clock", 32'h0, {31'h0, sys_clk_crystal});
        rchk("rc flag", A_PMR, 32'hff, 32'h41);
        wr(A_PMR, 32'h09);
        cyc(1);
        chk("main enable", 32'h0, {31'h0, main_osc_en});
        rchk("ready cleared", A_ST, 32'h10, 32'h0);
        wr(A_PMR, 32'h89);
        rchk("select refused", A_PMR, 32'hff, 32'h49);
        wr(A_PMR, 32'h01);
        rchk("not yet warm", A_ST, 32'h10, 32'h0);
        wait_bit("main warm", A_ST, 32'h10);
        wr(A_PMR, 32'h81);
        cyc(2);
        chk("crystal clock", 32'h1, {31'h0, sys_clk_crystal});
        rchk("select taken", A_PMR, 32'hff, 32'h81);
        $display("test main oscillator done");
    endtask
    task automatic t_sub();
        wr(A_PMR, 32'h91);
        cyc(1);
        chk("sub enable", 32'h0, {31'h0, sub_osc_en});
        rchk("sub cleared", A_ST, 32'h80, 32'h0);
        wr(A_PMR, 32'h81);
        wait_bit("sub warm", A_ST, 32'h80);
        cyc(10);
        rchk("sub ready event", A_STS, 32'h2, 32'h2);
        $display("test sub oscillator done");
    endtask
    task automatic t_resume();
        int i;
        wr(A_PMR, 32'h01);
        pulse(4'h1);
        cyc(1);
        chk("hold on resume", 32'h1, {31'h0, cpu_hold});
        rchk("ready on resume", A_ST, 32'h10, 32'h0);
        for (i = 0; i < 300 && cpu_hold !== 1'b0; i++) begin
            @(posedge pclk);
        end
        chk("hold released", 32'h0, {31'h0, cpu_hold});
        if (cpu_hold !== 1'b0) begin
            print_verdict();
        end
        rchk("ready after hold", A_ST, 32'h10, 32'h10);
        wr(A_PMR, 32'h81);
        wr(A_PMR, 32'ha1);
        pulse(4'h1);
        cyc(2);
        chk("no hold on rc", 32'h0, {31'h0, cpu_hold});
        chk("rc after resume", 32'h0, {31'h0, sys_clk_crystal});
        rchk("pmr after resume", A_PMR, 32'hff, 32'h61);
        $display("test resume done");
    endtask
    task automatic t_irq();
        wr(A_CLR, 32'h7);
        wr(A_EN, 32'h4);
        rchk("enable", A_EN, 32'h7, 32'h4);
        pulse(4'h1);
        cyc(2);
        chk("irq raised", 32'h1, {31'h0, irq});
        rchk("event sticky", A_STS, 32'h4, 32'h4);
        wr(A_CLR, 32'h4);
        cyc(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(A_EN, 32'h0);
        pulse(4'h1);
        cyc(2);
        chk("irq masked", 32'h0, {31'h0, irq});
        rchk("masked event", A_STS, 32'h4, 32'h4);
        rchk("clear reads 0", A_CLR, 32'hff, 32'h0);
        wait_bit("main warm again", A_ST, 32'h10);
        rchk("main ready event", A_STS, 32'h1, 32'h1);
        $display("test interrupt done");
    endtask
    // Second reset with both straps on the long warm-up
    task automatic t_straps();
        @(posedge pclk);
        presetn <= 1'b0;
        main_long_opt <= 1'b1;
        sub_long_opt <= 1'b1;
        cyc(4);
        presetn <= 1'b1;
        rchk("pmr after reset", A_PMR, 32'hff, 32'h81);
        rchk("status after reset", A_ST, 32'hff, 32'h10);
        wr(A_PMR, 32'h11);
        cyc(2);
        wr(A_PMR, 32'h09);
        wr(A_PMR, 32'h01);
        cyc(50);
        rchk("long warm-up", A_ST, 32'h90, 32'h0);
        wait_bit("main long warm", A_ST, 32'h10);
        wait_bit("sub long warm", A_ST, 32'h80);
        $display("test strap options done");
    endtask
    task automatic t_service();
        pulse(4'h2);
        rchk("high service", A_ST, 32'h60, 32'h40);
        pulse(4'h4);
        rchk("both service", A_ST, 32'h60, 32'h60);
        pulse(4'h8);
        rchk("reti high", A_ST, 32'h60, 32'h20);
        pulse(4'h8);
        rchk("reti low", A_ST, 32'h60, 32'h00);
        $display("test in service done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        ev = 4'h0;
        main_long_opt = 1'b0;
        sub_long_opt = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_main_off();
        t_sub();
        t_resume();
        t_irq();
        t_service();
        t_straps();
        print_verdict();
    end
endmodule // tb_osc_select_warmup_ctrl
`default_nettype wire
